// ### include/sir_pkg.sv
// Constants and carrier types for the SDRAM init and self-refresh sequencer.
// Assumes a single 100 MHz device clock and a synchronous high reset.
package sir_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int PWRUP_US = 200;                 // Stable clock before CKE
  localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
  localparam int TRAS_NS = 40;                   // Least self-refresh stay
  localparam int TRAS_CYC = (TRAS_NS * CLK_MHZ + 999) / 1000;
  localparam int TRC_NS = 55;
  localparam int TIS_NS = 2;                     // 1.5 ns rounded up
  localparam int TXSR_CYC = ((TRC_NS + TIS_NS) * CLK_MHZ + 999) / 1000;
  localparam int REFRESH_INTERVAL_NS = 7800;                // refresh_interval, max
  localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS * CLK_MHZ / 1000;
  localparam int INIT_AREF_MIN = 2;
  localparam int BURST_AREF = 8192;
  localparam int PAGE_COLS = 512;
  localparam int COL_W = 9;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    SIR_CMD_NOP, SIR_CMD_PRE, SIR_CMD_MRS, SIR_CMD_AREF,
    SIR_CMD_SREF, SIR_CMD_DESEL, SIR_CMD_ACC
  } sir_cmd_t;

  typedef enum logic [2:0] {
    SIR_ST_PWRUP, SIR_ST_WAITPRE, SIR_ST_INIT, SIR_ST_IDLE,
    SIR_ST_SREF, SIR_ST_XSR
  } sir_state_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic dqm;
  } sir_pins_t;
endpackage

// ### rtl/sir_seq.sv
// Device-side init and self-refresh tracker with full-page column counter.
// Assumes controller pins are synchronous to clk_i; clock may stop in self
// refresh, in which case only cke is meaningful.
//
// What this block does; R1-R3, R11-R13, R15, R17 and R19 are left to the controller
// R1 - Controller holds CKE low, NOP at power
// R2 - 200 us stable clock before CKE high
// R3 - DQM kept high during init
// R4 - Precharge all banks first after CKE
// R5 - Mode register set during init
// R6 - At least two dummy auto refreshes
// R7 - Refreshes before or after mode set
// R8 - CS RAS CAS low with CKE low enters
// R9 - One cycle later ignore all but CKE
// R10 - Stay in self refresh while CKE low
// R11 - Stay at least row active time
// R12 - Clock stable before CKE high on exit
// R13 - CS held high at exit
// R14 - Wait exit time before real commands
// R15 - Burst refresh 8192 around self refresh
// R16 - Full page burst wraps column counter
// R17 - Row active time 40 ns minimum
// R18 - Exit time is row cycle plus setup
// R19 - Refresh every 7.8 us on average
// R20 - Self refresh entry has WE high
// R21 - No accesses before init completes
`timescale 1ns/1ps
module sir_seq #(
  parameter int COL_W = sir_pkg::COL_W
) (
  input wire logic clk_i,                 // Device clock
  input wire logic srst_i,                // Sync reset, high
  input wire sir_pkg::sir_pins_t pins_i,  // Controller command pins
  input wire logic [COL_W-1:0] col_i,     // Burst start column
  input wire logic burst_start_i,         // Full page burst begins
  input wire logic burst_stop_i,          // Burst terminated
  output logic init_done_o,               // Init sequence complete
  output logic in_sref_o,                 // Self refresh active
  output logic inputs_ignored_o,          // Only CKE is heard
  output logic cmd_ready_o,               // Real commands accepted
  output logic burst_act_o,               // Full page burst running
  output logic [COL_W-1:0] col_o          // Current burst column
);
  // Elaboration check: counter width must fit the 16-bit column space
  if (COL_W < 1 || COL_W > 16) begin : g_bad_col_w
    $error("COL_W out of range");
  end

  // ==========================================================================
  // Command decode
  function automatic sir_pkg::sir_cmd_t decode(sir_pkg::sir_pins_t p);
    if (p.cs_n) return sir_pkg::SIR_CMD_DESEL;
    if (!p.ras_n && !p.cas_n && p.we_n)                             // R20
      return p.cke ? sir_pkg::SIR_CMD_AREF : sir_pkg::SIR_CMD_SREF; // R8
    if (!p.ras_n && !p.cas_n && !p.we_n) return sir_pkg::SIR_CMD_MRS;
    if (!p.ras_n && p.cas_n && !p.we_n) return sir_pkg::SIR_CMD_PRE;
    if (p.ras_n && p.cas_n && p.we_n) return sir_pkg::SIR_CMD_NOP;
    return sir_pkg::SIR_CMD_ACC;
  endfunction

  sir_pkg::sir_cmd_t cmd;
  assign cmd = decode(pins_i);

  // ==========================================================================
  // Sequencer state
  sir_pkg::sir_state_t st_q, st_d;
  logic mrs_q, mrs_d;
  logic [1:0] aref_q, aref_d;
  logic [15:0] cnt_q, cnt_d;
  logic ign_q, ign_d;

  // Next state; sequence follows the controller's commands
  always_comb begin
    st_d = st_q;
    mrs_d = mrs_q;
    aref_d = aref_q;
    cnt_d = cnt_q;
    ign_d = 1'b0;
    case (st_q)
      sir_pkg::SIR_ST_PWRUP: begin
        if (pins_i.cke) st_d = sir_pkg::SIR_ST_WAITPRE;  // R2
      end
      sir_pkg::SIR_ST_WAITPRE: begin
        if (cmd == sir_pkg::SIR_CMD_PRE) st_d = sir_pkg::SIR_ST_INIT; // R4
      end
      sir_pkg::SIR_ST_INIT: begin
        // Either order of mode set and refreshes counts
        if (cmd == sir_pkg::SIR_CMD_MRS) mrs_d = 1'b1;  // R5 R7
        if (cmd == sir_pkg::SIR_CMD_AREF && aref_q != 2'd2)
          aref_d = aref_q + 2'd1;                        // R6
        if (mrs_d && aref_d == 2'(sir_pkg::INIT_AREF_MIN))
          st_d = sir_pkg::SIR_ST_IDLE;
      end
      sir_pkg::SIR_ST_IDLE: begin
        if (cmd == sir_pkg::SIR_CMD_SREF) begin          // R8
          st_d = sir_pkg::SIR_ST_SREF;
          ign_d = 1'b1;                                  // R9
        end
      end
      sir_pkg::SIR_ST_SREF: begin
        ign_d = 1'b1;                                    // R9
        if (pins_i.cke) begin                            // R10
          st_d = sir_pkg::SIR_ST_XSR;
          ign_d = 1'b0;
          cnt_d = 16'h0000;
        end
      end
      sir_pkg::SIR_ST_XSR: begin
        // Only deselect/NOP honoured until exit time passes
        cnt_d = cnt_q + 16'h0001;                        // R14 R18
        if (cnt_d >= 16'(sir_pkg::TXSR_CYC)) st_d = sir_pkg::SIR_ST_IDLE;
      end
      default: st_d = sir_pkg::SIR_ST_PWRUP;
    endcase
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= sir_pkg::SIR_ST_PWRUP;
      mrs_q <= 1'b0;
      aref_q <= 2'd0;
      cnt_q <= 16'h0000;
      ign_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mrs_q <= mrs_d;
      aref_q <= aref_d;
      cnt_q <= cnt_d;
      ign_q <= ign_d;
    end
  end

  // ==========================================================================
  // Full-page column counter; wraps instead of stopping at page end
  logic act_q, act_d;
  logic [COL_W-1:0] col_q, col_d;

  always_comb begin
    act_d = act_q;
    col_d = col_q;
    if (burst_stop_i || ign_q) begin
      act_d = 1'b0;
    end else if (burst_start_i && st_q == sir_pkg::SIR_ST_IDLE) begin
      act_d = 1'b1;                                      // R21
      col_d = col_i;
    end else if (act_q) begin
      col_d = col_q + 1'b1;                              // R16
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      act_q <= 1'b0;
      col_q <= '0;
    end else begin
      act_q <= act_d;
      col_q <= col_d;
    end
  end

  // ==========================================================================
  // Outputs, all registered
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      init_done_o <= 1'b0;
      in_sref_o <= 1'b0;
      inputs_ignored_o <= 1'b0;
      cmd_ready_o <= 1'b0;
    end else begin
      init_done_o <= st_d inside {sir_pkg::SIR_ST_IDLE,
                                  sir_pkg::SIR_ST_SREF,
                                  sir_pkg::SIR_ST_XSR};
      in_sref_o <= (st_d == sir_pkg::SIR_ST_SREF);
      inputs_ignored_o <= ign_d;
      cmd_ready_o <= (st_d == sir_pkg::SIR_ST_IDLE);
    end
  end
  assign burst_act_o = act_q;
  assign col_o = col_q;

  // ==========================================================================
  // Checks
  chk_sref_entry: assert property (@(posedge clk_i) disable iff (srst_i)
    st_q == sir_pkg::SIR_ST_IDLE && cmd == sir_pkg::SIR_CMD_SREF
    |=> in_sref_o && inputs_ignored_o) // R8
    else $error("self refresh entry missed");
  chk_sref_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    in_sref_o && !pins_i.cke |=> in_sref_o) // R10
    else $error("left self refresh with cke low");
  chk_ignore_inputs: assert property (@(posedge clk_i) disable iff (srst_i)
    in_sref_o && !pins_i.cke |=> !cmd_ready_o && !burst_act_o) // R9
    else $error("inputs heard in self refresh");
  chk_exit_wait: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(in_sref_o) |-> !cmd_ready_o [*5]) // R14
    else $error("exit time too short");
  chk_exit_done: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(in_sref_o) |-> ##[1:8] cmd_ready_o) // R18
    else $error("exit never completes");
  chk_col_wrap: assert property (@(posedge clk_i) disable iff (srst_i)
    burst_act_o && !burst_stop_i && !burst_start_i && !ign_q
    |=> col_o == $past(col_o) + 1'b1) // R16
    else $error("column not advancing");
  chk_no_early: assert property (@(posedge clk_i) disable iff (srst_i)
    !init_done_o |-> !cmd_ready_o) // R21
    else $error("ready before init");
  chk_init_order: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(init_done_o) |-> mrs_q && aref_q == 2'd2) // R6
    else $error("init finished early");
  chk_we_high: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(in_sref_o) |-> $past(pins_i.we_n) && !$past(pins_i.cke)) // R20
    else $error("entry without we high");

  cov_init: cover property (@(posedge clk_i) $rose(init_done_o));
  cov_sref: cover property (@(posedge clk_i) $rose(in_sref_o));
  cov_exit: cover property (@(posedge clk_i)
    $fell(in_sref_o) ##[1:8] cmd_ready_o);
  cov_wrap: cover property (@(posedge clk_i)
    burst_act_o && col_o == '1 ##1 col_o == '0);
endmodule // sir_seq

// ### tb/sir_ctrl_model.sv
// Controller model: drives the command pins of the init/self-refresh tracker.
// Assumes one testbench process calls its tasks, one at a time.
`timescale 1ns/1ps
module sir_ctrl_model (
  input wire logic clk_i,           // Device clock
  output sir_pkg::sir_pins_t pins_o // Command pins to the device
);
  // ==========================================================================
  // Power-up level: clock enable low, mask high, no-operation
  initial pins_o = 6'h0f;
  // One command per edge; the mask stays high so data lines stay quiet
  task automatic put(input logic [4:0] v);
    @(posedge clk_i);
    pins_o <= {v, 1'h1};
  endtask
  // ==========================================================================
  // Power-up sequence; refreshes may sit either side of the mode set
  task automatic do_init(input bit mrs_first);
    repeat (sir_pkg::PWRUP_CYC) @(posedge clk_i);
    put(5'h17);
    put(5'h12);
    if (mrs_first) put(5'h10);
    put(5'h11);
    put(5'h11);
    if (!mrs_first) put(5'h10);
    put(5'h17);
  endtask
  // Back-to-back refreshes; keeps the refresh average well inside limits
  task automatic burst_refresh();
    repeat (sir_pkg::BURST_AREF) put(5'h11);
  endtask
  // Entry, then junk on every pin but clock enable and mask, so ignoring is tested
  task automatic sref_enter();
    logic [3:0] j;
    j = 4'ha;
    burst_refresh();
    put(5'h01);
    repeat (sir_pkg::TRAS_CYC + 2) begin
      put({1'h0, j});
      j = ~j;
    end
  endtask
  // Clock already stable; clock enable returns with chip select high
  task automatic sref_exit();
    put(5'h1f);
  endtask
  // Real commands only after the exit time has run out
  task automatic resume();
    put(5'h17);
    burst_refresh();
    put(5'h17);
  endtask
endmodule // sir_ctrl_model

// ### tb/sir_seq_tb_top.sv
// Self-checking bench for the init and self-refresh tracker.
// Assumes the controller model drives the pins; bursts come from here.
`timescale 1ns/1ps
module sir_seq_tb_top;
  logic clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic [8:0] col_i = 9'h000;
  logic burst_start_i = 1'h0;
  logic burst_stop_i = 1'h0;
  logic init_done_o, in_sref_o, inputs_ignored_o, cmd_ready_o, burst_act_o;
  logic [8:0] col_o;
  sir_pkg::sir_pins_t pins;
  int err_total = 0;
  int cmp_count = 0;
  sir_ctrl_model i_sir_ctrl_model (.clk_i(clk_i), .pins_o(pins));
  sir_seq i_sir_seq (.clk_i(clk_i), .srst_i(srst_i), .pins_i(pins),
    .col_i(col_i), .burst_start_i(burst_start_i),
    .burst_stop_i(burst_stop_i), .init_done_o(init_done_o),
    .in_sref_o(in_sref_o), .inputs_ignored_o(inputs_ignored_o),
    .cmd_ready_o(cmd_ready_o), .burst_act_o(burst_act_o), .col_o(col_o));
  // ==========================================================================
  // Clock and checks
  initial forever #5 clk_i = ~clk_i;
  task automatic chk_bit(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic chk_col(input logic [8:0] exp);
    cmp_count++;
    if (col_o !== exp) begin
      err_total++;
      $display("BAD %0t column %h want %h", $time, col_o, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_init(input bit mrs_first);
    i_sir_ctrl_model.put(5'h07);
    srst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'h0;
    burst_start_i <= 1'h1;
    @(posedge clk_i);
    burst_start_i <= 1'h0;
    @(posedge clk_i) #1;
    chk_bit(burst_act_o, 1'h0, "burst before init");
    chk_bit(init_done_o, 1'h0, "done too early");
    i_sir_ctrl_model.do_init(mrs_first);
    @(posedge clk_i) #1;
    chk_bit(init_done_o, 1'h1, "init not done");
    chk_bit(cmd_ready_o, 1'h1, "not ready");
  endtask
  // Full-page burst started near the top must wrap to column zero
  task automatic t_burst();
    @(posedge clk_i);
    burst_start_i <= 1'h1;
    col_i <= 9'h1fe;
    @(posedge clk_i);
    burst_start_i <= 1'h0;
    #1 chk_bit(burst_act_o, 1'h1, "burst idle");
    chk_col(9'h1fe);
    @(posedge clk_i) #1 chk_col(9'h1ff);
    @(posedge clk_i) #1 chk_col(9'h000);
    @(posedge clk_i) #1 chk_col(9'h001);
    @(posedge clk_i);
    burst_stop_i <= 1'h1;
    @(posedge clk_i);
    burst_stop_i <= 1'h0;
    #1 chk_bit(burst_act_o, 1'h0, "burst not stopped");
  endtask
  // Entry, stay under junk, refused burst, timed exit
  task automatic t_sref();
    int n;
    i_sir_ctrl_model.sref_enter();
    #1 chk_bit(in_sref_o, 1'h1, "left early");
    chk_bit(inputs_ignored_o, 1'h1, "inputs heard");
    chk_bit(cmd_ready_o, 1'h0, "ready in sref");
    @(posedge clk_i);
    burst_start_i <= 1'h1;
    @(posedge clk_i);
    burst_start_i <= 1'h0;
    @(posedge clk_i) #1 chk_bit(burst_act_o, 1'h0, "burst in sref");
    i_sir_ctrl_model.sref_exit();
    @(posedge clk_i) #1 chk_bit(in_sref_o, 1'h0, "no exit");
    n = 1;
    while (cmd_ready_o !== 1'h1 && n < 20) begin
      @(posedge clk_i) #1;
      n++;
    end
    chk_bit(n inside {[sir_pkg::TXSR_CYC : sir_pkg::TXSR_CYC + 1]}, 1'h1,
      "exit time wrong");
    i_sir_ctrl_model.resume();
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge clk_i);
    t_init(1'h1);
    t_burst();
    t_sref();
    t_init(1'h0);
    t_sref();
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    stop_test();
  end
endmodule // sir_seq_tb_top
